// ---- logic/swmw_ctrl.sv ----
// mode controller, serial command port and watchdog supervision of the high side switch
// ==========================================================
// What this block does
// RULE_01: serial output released while chip select high
// RULE_02: serial output changes on rising serial clock
// RULE_03: both supplies present gives normal mode
// RULE_04: fault kinds reported over serial port
// RULE_05: command lets direct input drive load
// RULE_06: sleep after power up or wake/reset low
// RULE_07: sleep clears every configurable setting
// RULE_08: normal mode runs watchdog when enabled
// RULE_09: fault mode pulls flag low, output off
// RULE_10: wake or reset rise arms watchdog
// RULE_11: missed toggle before timeout latches failsafe
// RULE_12: timeout counted in clocks, selected period
// RULE_13: failsafe output follows select resistor
// RULE_14: failsafe entry defaults overcurrent fields only
// RULE_15: timeout status bit set during failsafe
// RULE_16: wake/reset low or grounded select exits
// RULE_17: grounded select disables watchdog and failsafe
// RULE_18: logic supply loss resets, direct input drives
// RULE_19: eight bit frames, msb first, rising capture
// RULE_20: fault flag pulled low on any fault
// RULE_21: reset low clears registers, rise starts watchdog
// RULE_22: watchdog restarts only on toggled bit
`timescale 1ns/1ps
`default_nettype none
module swmw_ctrl
   import swmw_pkg::*;
#(
   parameter int unsigned WD_TIME0_US = 10000,
   parameter int unsigned WD_TIME1_US = 50000,
   parameter int unsigned WD_TIME2_US = 100000,
   parameter int unsigned WD_TIME3_US = 200000
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // serial port
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_o,
   // control pins
   input wire logic wake_i,
   input wire logic reset_pin_n_i,
   input wire logic direct_in_i,
   input wire logic [1:0] failsafe_select_resistor_i,
   // supplies
   input wire logic battery_supply_ok_i,
   input wire logic logic_supply_ok_i,
   // fault detectors: open, resistive, severe, thermal, under, over
   input wire logic [5:0] fault_det_i,
   // outputs
   output logic fault_flag_n_o,
   output logic fault_flag_n_oe_o,
   output logic power_output_o,
   output logic watchdog_expired_flag_o,
   output logic [1:0] mode_o,
   output logic regulator_en_o,
   output logic overcurrent_high_level_o,
   output logic [2:0] overcurrent_low_level_o,
   output logic [1:0] overcurrent_low_time_o
);
   // ==========================================================
   // timing
   localparam logic [WD_CNT_W-1:0] WD_CYC0 = WD_CNT_W'(WD_TIME0_US * CLK_MHZ);
   localparam logic [WD_CNT_W-1:0] WD_CYC1 = WD_CNT_W'(WD_TIME1_US * CLK_MHZ);
   localparam logic [WD_CNT_W-1:0] WD_CYC2 = WD_CNT_W'(WD_TIME2_US * CLK_MHZ);
   localparam logic [WD_CNT_W-1:0] WD_CYC3 = WD_CNT_W'(WD_TIME3_US * CLK_MHZ);

   function automatic logic [WD_CNT_W-1:0] wd_limit(input logic [1:0] sel);
      unique case (sel)
         2'h0: wd_limit = WD_CYC0;
         2'h1: wd_limit = WD_CYC1;
         2'h2: wd_limit = WD_CYC2;
         2'h3: wd_limit = WD_CYC3;
      endcase
   endfunction
   // ==========================================================
   // input synchronisation
   logic [SYNC_W-1:0] s;
   logic sclk_d, cs_d, wake_d, rst_d;
   logic [1:0] warm;
   swmw_sync #(.W(SYNC_W)) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .d_i({fault_det_i, failsafe_select_resistor_i, logic_supply_ok_i, battery_supply_ok_i,
            direct_in_i, reset_pin_n_i, wake_i, si_i, cs_n_i, sclk_i}),
      .q_o(s)
   );
   // the synchroniser resets to zero, which would look like a selected port until it has filled
   wire logic cs_s = s[S_CS] || !warm[1]; // [RULE_01]
   wire logic wake_s = s[S_WAKE];
   wire logic rst_s = s[S_RST];
   wire logic din_s = s[S_DIN];
   wire logic vdd_s = s[S_VDD];
   wire logic [1:0] fsr_s = s[S_FSR+1:S_FSR];
   wire logic [5:0] flt_s = s[S_FLT+5:S_FLT];
   wire logic sclk_rise = s[S_SCLK] && !sclk_d;
   wire logic cs_fall = !cs_s && cs_d;
   wire logic cs_rise = cs_s && !cs_d;
   wire logic grounded = (fsr_s == FSR_GND);
   wire logic sleep_cond = !wake_s && !rst_s;
   wire logic pin_rise = (wake_s && !wake_d) || (rst_s && !rst_d);
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         warm <= 2'h0;
         sclk_d <= 1'b0;
         cs_d <= 1'b1;
         wake_d <= 1'b0;
         rst_d <= 1'b0;
      end else begin
         warm <= {warm[0], 1'h1};
         sclk_d <= s[S_SCLK];
         cs_d <= cs_s;
         wake_d <= wake_s;
         rst_d <= rst_s;
      end
   end
   // ==========================================================
   // serial frame reception and response shifting
   logic [FRAME_BITS-1:0] rx_sh, tx_sh;
   logic [3:0] bit_cnt;
   logic [5:0] flt_reg;
   logic [1:0] wdr_sel;
   logic frame_ok, rsp_wdr, wd_prev, wd_restart;
   swmw_mode_type mode, next_mode;
   // bits past the eighth still shift, but a longer frame fails the length check and is not taken
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_sh <= '0;
         bit_cnt <= '0;
      end else if (cs_s) begin
         bit_cnt <= '0;
      end else if (sclk_rise) begin
         rx_sh <= {rx_sh[FRAME_BITS-2:0], s[S_SI]}; // [RULE_19]
         bit_cnt <= (bit_cnt == 4'hF) ? bit_cnt : bit_cnt + 4'h1;
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frame_ok <= 1'b0;
      end else begin
         frame_ok <= cs_rise && (bit_cnt == FRAME_LEN) && vdd_s; // [RULE_19]
      end
   end
   // response word is loaded at frame start, msb goes out on the first rising edge
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_sh <= '0;
         so_o <= 1'b0;
      end else if (cs_fall) begin
         tx_sh <= rsp_wdr ? {5'h00, watchdog_expired_flag_o, wdr_sel} : {2'h0, flt_reg}; // [RULE_04] [RULE_15]
      end else if (sclk_rise && !cs_s) begin
         so_o <= tx_sh[FRAME_BITS-1]; // [RULE_02]
         tx_sh <= {tx_sh[FRAME_BITS-2:0], 1'b0};
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         so_oe_o <= 1'b0;
      end else begin
         so_oe_o <= !cs_s && vdd_s; // [RULE_01]
      end
   end
   // fault latch, cleared by a completed frame; a fault present then sets it again
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flt_reg <= '0;
      end else if (!rst_s || !vdd_s) begin
         flt_reg <= '0; // [RULE_21] [RULE_18]
      end else if (frame_ok) begin
         flt_reg <= flt_s; // [RULE_04]
      end else begin
         flt_reg <= flt_reg | flt_s; // [RULE_04]
      end
   end
   // ==========================================================
   // configuration registers
   logic out_on, out_pwm, fs_latch, fs_set;
   wire logic [2:0] cmd_addr = rx_sh[ADDR_MSB:ADDR_LSB];
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_on <= 1'b0;
         out_pwm <= 1'b0;
         wdr_sel <= WDR_DEF;
         rsp_wdr <= 1'b0;
      end else if (!rst_s || !vdd_s || sleep_cond) begin
         out_on <= 1'b0; // [RULE_07] [RULE_18] [RULE_21]
         out_pwm <= 1'b0;
         wdr_sel <= WDR_DEF;
         rsp_wdr <= 1'b0;
      end else if (frame_ok) begin
         rsp_wdr <= (cmd_addr == ADDR_WDR);
         if (cmd_addr == ADDR_OUT) begin
            out_on <= rx_sh[OUT_ON_POS];
            out_pwm <= rx_sh[OUT_PWM_POS]; // [RULE_05]
         end
         if (cmd_addr == ADDR_WDR) begin
            wdr_sel <= rx_sh[1:0]; // [RULE_12]
         end
      end
   end
   // failsafe entry only touches the overcurrent settings, everything else survives
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         overcurrent_high_level_o <= OCH_DEF;
         overcurrent_low_level_o <= OCL_DEF;
         overcurrent_low_time_o <= OCT_DEF;
      end else if (!rst_s || !vdd_s || sleep_cond || fs_set) begin
         overcurrent_high_level_o <= OCH_DEF; // [RULE_14] [RULE_07] [RULE_18]
         overcurrent_low_level_o <= OCL_DEF;
         overcurrent_low_time_o <= OCT_DEF;
      end else if (frame_ok) begin
         if (cmd_addr == ADDR_OCH) begin
            overcurrent_high_level_o <= rx_sh[0];
         end
         if (cmd_addr == ADDR_OCL) begin
            overcurrent_low_level_o <= rx_sh[2:0];
         end
         if (cmd_addr == ADDR_OCT) begin
            overcurrent_low_time_o <= rx_sh[1:0];
         end
      end
   end
   // ==========================================================
   // watchdog
   logic wd_armed, wd_expired;
   wire logic wd_run = wd_armed && !grounded && !fs_latch && (mode != M_SLEEP); // [RULE_08] [RULE_17]
   // a frame is taken as a toggle only when bit seven differs from the last frame
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wd_prev <= 1'b0;
         wd_restart <= 1'b0;
      end else begin
         wd_restart <= (frame_ok && (rx_sh[WD_BIT_POS] != wd_prev)) || pin_rise; // [RULE_22] [RULE_21]
         if (frame_ok) begin
            wd_prev <= rx_sh[WD_BIT_POS]; // [RULE_11]
         end
      end
   end
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wd_armed <= 1'b0;
      end else if (grounded || sleep_cond) begin
         wd_armed <= 1'b0; // [RULE_17]
      end else if (pin_rise) begin
         wd_armed <= 1'b1; // [RULE_10]
      end
   end
   swmw_wdog u_wdog (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .run_i(wd_run),
      .restart_i(wd_restart),
      .limit_i(wd_limit(wdr_sel)), // [RULE_12]
      .expired_o(wd_expired)
   );
   // exit wins over a timeout in the same cycle: grounding the select disables the feature
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fs_latch <= 1'b0;
         fs_set <= 1'b0;
      end else begin
         fs_set <= 1'b0;
         if (grounded || sleep_cond) begin
            fs_latch <= 1'b0; // [RULE_16] [RULE_17]
         end else if (wd_expired && !fs_latch) begin
            fs_latch <= 1'b1; // [RULE_11]
            fs_set <= 1'b1; // [RULE_14]
         end
      end
   end

   // ==========================================================
   // mode selection and outputs
   always_comb begin
      if (!s[S_BAT] || sleep_cond) begin
         next_mode = M_SLEEP; // [RULE_06]
      end else if (fs_latch) begin
         next_mode = M_FAILSAFE; // [RULE_11]
      end else if (|flt_s) begin
         next_mode = M_FAULT; // [RULE_09]
      end else begin
         next_mode = M_NORMAL; // [RULE_03] [RULE_08]
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode <= M_SLEEP; // [RULE_06]
      end else begin
         mode <= next_mode;
      end
   end

   // without the logic supply the serial settings are gone, so in normal mode the direct input rules
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         power_output_o <= 1'b0;
      end else begin
         unique case (mode)
            M_SLEEP: power_output_o <= 1'b0; // [RULE_06]
            M_FAULT: power_output_o <= 1'b0; // [RULE_09]
            M_FAILSAFE: power_output_o <= (fsr_s == FSR_30K); // [RULE_13]
            M_NORMAL: power_output_o <= !vdd_s ? din_s : (out_pwm ? din_s : out_on); // [RULE_18] [RULE_05]
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fault_flag_n_o <= 1'b0;
         fault_flag_n_oe_o <= 1'b0;
         watchdog_expired_flag_o <= 1'b0;
         mode_o <= 2'h0;
         regulator_en_o <= 1'b0;
      end else begin
         fault_flag_n_o <= 1'b0;
         fault_flag_n_oe_o <= (|flt_s) && !sleep_cond && s[S_BAT]; // [RULE_20] [RULE_09]
         watchdog_expired_flag_o <= (mode == M_FAILSAFE); // [RULE_15]
         mode_o <= mode;
         regulator_en_o <= (mode != M_SLEEP); // [RULE_07]
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_toggle_frame;
      frame_ok && (rx_sh[WD_BIT_POS] != wd_prev);
   endsequence

   sequence s_stale_frame;
      frame_ok && (rx_sh[WD_BIT_POS] == wd_prev) && !pin_rise;
   endsequence

   chk_so_release: assert property (cs_s |=> !so_oe_o) // [RULE_01]
      else $error("serial output driven while deselected");
   chk_so_shift: assert property (sclk_rise && !cs_s && !cs_fall |=> so_o == $past(tx_sh[FRAME_BITS-1])) // [RULE_02]
      else $error("serial output did not take next bit on rising clock");
   chk_sleep_off: assert property (mode == M_SLEEP |=> !power_output_o && !regulator_en_o) // [RULE_06]
      else $error("output or regulator on in sleep");
   chk_sleep_clears: assert property (sleep_cond |=> !out_on && !out_pwm && wdr_sel == WDR_DEF) // [RULE_07]
      else $error("settings kept in sleep");
   chk_fault_flag: assert property (next_mode == M_FAULT |=> fault_flag_n_oe_o ##1 !power_output_o) // [RULE_09]
      else $error("fault mode without flag or with output on");
   chk_fs_output: assert property (mode == M_FAILSAFE && fsr_s == FSR_30K && $stable(fsr_s)
      |=> power_output_o) // [RULE_13]
      else $error("failsafe output not on with high select resistor");
   chk_oc_default: assert property ($rose(fs_latch) |=> overcurrent_low_level_o == OCL_DEF
      && overcurrent_high_level_o == OCH_DEF) // [RULE_14]
      else $error("overcurrent settings kept on failsafe entry");
   chk_watchdog_expired_flag_bit: assert property (mode == M_FAILSAFE |=> watchdog_expired_flag_o) // [RULE_15]
      else $error("timeout status clear in failsafe");
   chk_gnd_disable: assert property (grounded |=> !fs_latch && !wd_armed && !wd_expired) // [RULE_17]
      else $error("watchdog active with grounded select");
   chk_wd_restart: assert property (s_toggle_frame |=> wd_restart) // [RULE_22]
      else $error("toggled frame did not restart watchdog");
   chk_wd_norestart: assert property (s_stale_frame |=> !wd_restart) // [RULE_22]
      else $error("untoggled frame restarted watchdog");
endmodule // swmw_ctrl
`default_nettype wire

// ---- pkg/swmw_pkg.sv ----
// constants, command layout and mode type for the switch mode and watchdog controller
package swmw_pkg;
   // ==========================================================
   // clock and timing
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned WD_CNT_W = 32;
   // ==========================================================
   // frame layout: toggle bit, address field, data field
   localparam int unsigned FRAME_BITS = 8;
   localparam logic [3:0] FRAME_LEN = 4'h8;
   localparam int unsigned WD_BIT_POS = 7;
   localparam int unsigned ADDR_MSB = 6;
   localparam int unsigned ADDR_LSB = 4;
   // ==========================================================
   // command addresses
   localparam logic [2:0] ADDR_OUT = 3'h0;
   localparam logic [2:0] ADDR_OCH = 3'h1;
   localparam logic [2:0] ADDR_OCL = 3'h2;
   localparam logic [2:0] ADDR_OCT = 3'h3;
   localparam logic [2:0] ADDR_WDR = 3'h4;
   // ==========================================================
   // field positions and reset values
   localparam int unsigned OUT_ON_POS = 0;
   localparam int unsigned OUT_PWM_POS = 1;
   localparam int unsigned WATCHDOG_EXPIRED_FLAG_POS = 2;
   localparam logic OCH_DEF = 1'h0;
   localparam logic [2:0] OCL_DEF = 3'h0;
   localparam logic [1:0] OCT_DEF = 2'h0;
   localparam logic [1:0] WDR_DEF = 2'h0;
   // ==========================================================
   // failsafe select resistor codes
   localparam logic [1:0] FSR_GND = 2'h0;
   localparam logic [1:0] FSR_10K = 2'h1;
   localparam logic [1:0] FSR_30K = 2'h2;
   // ==========================================================
   // synchronised input vector positions
   localparam int unsigned SYNC_W = 16;
   localparam int unsigned S_SCLK = 0;
   localparam int unsigned S_CS = 1;
   localparam int unsigned S_SI = 2;
   localparam int unsigned S_WAKE = 3;
   localparam int unsigned S_RST = 4;
   localparam int unsigned S_DIN = 5;
   localparam int unsigned S_BAT = 6;
   localparam int unsigned S_VDD = 7;
   localparam int unsigned S_FSR = 8;
   localparam int unsigned S_FLT = 10;

   typedef enum logic [1:0] {M_SLEEP, M_NORMAL, M_FAULT, M_FAILSAFE} swmw_mode_type;
endpackage

// ---- logic/swmw_sync.sv ----
// two flip-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module swmw_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               meta[g] <= 1'b0;
               q_o[g] <= 1'b0;
            end else begin
               meta[g] <= d_i[g];
               q_o[g] <= meta[g];
            end
         end
      end
   endgenerate
endmodule // swmw_sync
`default_nettype wire

// ---- logic/swmw_wdog.sv ----
// watchdog timeout counter
`timescale 1ns/1ps
`default_nettype none
module swmw_wdog
   import swmw_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // control
   input wire logic run_i,
   input wire logic restart_i,
   input wire logic [WD_CNT_W-1:0] limit_i,
   // status
   output logic expired_o
);
   logic [WD_CNT_W-1:0] count;

   // counts system clock cycles as the internal oscillator
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count <= '0;
      end else if (!run_i || restart_i) begin
         count <= '0;
      end else if (count < limit_i) begin
         count <= count + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         expired_o <= 1'b0;
      end else begin
         expired_o <= run_i && !restart_i && (count >= limit_i);
      end
   end
endmodule // swmw_wdog
`default_nettype wire

// ---- bench/swmw_host.sv ----
// serial host model: sends frames msb first and samples the answer on the falling serial clock
`timescale 1ns/1ps
`default_nettype none
module swmw_host (
   // serial port, host side
   output logic sclk_o,
   output logic cs_n_o,
   output logic si_o,
   input wire logic so_i,
   input wire logic so_oe_i
);
   // ==========================================================
   // idle levels
   // clock stands low between frames, data is driven low
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
   end
   // ==========================================================
   // one frame, serial clock period 125 ns
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx, output logic oe_ok);
      rx = 8'h00;
      oe_ok = 1'b1;
      // small offset keeps serial edges away from system clock edges
      #1.3;
      cs_n_o = 1'b0;
      #62.5;
      for (int i = 7; i > 7 - nbits; i--) begin
         si_o = tx[i];
         #62.5 sclk_o = 1'b1;
         #62.5 sclk_o = 1'b0;
         rx[i] = so_i;
         oe_ok = oe_ok & so_oe_i;
      end
      #62.5 cs_n_o = 1'b1;
      si_o = 1'b0;
      #62.5;
   endtask
endmodule // swmw_host
`default_nettype wire

// ---- bench/swmw_ctrl_bench.sv ----
// self-checking bench of the switch mode and watchdog controller
`timescale 1ns/1ps
`default_nettype none
module swmw_ctrl_bench;
   import swmw_pkg::*;
   // ==========================================================
   // pins, counters and table
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic wake_i = 1'b0;
   logic reset_pin_n_i = 1'b0;
   logic direct_in_i = 1'b0;
   logic [1:0] failsafe_select_resistor_i = FSR_GND;
   logic battery_supply_ok_i = 1'b0;
   logic logic_supply_ok_i = 1'b0;
   logic [5:0] fault_det_i = 6'h00;
   logic sclk_i, cs_n_i, si_i, so_o, so_oe_o, fault_flag_n_o, fault_flag_n_oe_o, power_output_o;
   logic watchdog_expired_flag_o, regulator_en_o, overcurrent_high_level_o;
   logic [1:0] mode_o, overcurrent_low_time_o;
   logic [2:0] overcurrent_low_level_o;
   wire fault_pin = fault_flag_n_oe_o ? fault_flag_n_o : 1'b1;
   wire so_line = so_oe_o ? so_o : 1'bz;
   logic tg = 1'b0;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   typedef struct packed {logic din; logic [6:0] cmd; logic [7:0] outs; logic [7:0] rx;} swmw_row_type;
   // direct in, command, {power, oc high, oc low, oc time}, answer
   localparam swmw_row_type ROWS [9] = '{
      '{1'b0, 7'h11, 8'h20, 8'h00}, '{1'b0, 7'h25, 8'h34, 8'h00}, '{1'b0, 7'h32, 8'h36, 8'h00},
      '{1'b0, 7'h41, 8'h36, 8'h00}, '{1'b0, 7'h01, 8'h76, 8'h01}, '{1'b0, 7'h40, 8'h76, 8'h00},
      '{1'b1, 7'h03, 8'h76, 8'h00}, '{1'b0, 7'h03, 8'h36, 8'h00}, '{1'b0, 7'h01, 8'h76, 8'h00}};
   // ==========================================================
   // design and host; short periods keep the watchdog between 1000 and 2000 cycles
   swmw_ctrl #(.WD_TIME0_US(4), .WD_TIME1_US(5), .WD_TIME2_US(6), .WD_TIME3_US(8)) i_swmw_ctrl (
      .clk_sys_i, .rst_n_i, .sclk_i, .cs_n_i, .si_i, .so_o, .so_oe_o, .wake_i, .reset_pin_n_i, .direct_in_i,
      .failsafe_select_resistor_i, .battery_supply_ok_i, .logic_supply_ok_i, .fault_det_i, .fault_flag_n_o,
      .fault_flag_n_oe_o, .power_output_o, .watchdog_expired_flag_o, .mode_o, .regulator_en_o,
      .overcurrent_high_level_o, .overcurrent_low_level_o, .overcurrent_low_time_o);
   swmw_host i_swmw_host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .si_o(si_i), .so_i(so_line), .so_oe_i(so_oe_o));
   // ==========================================================
   // clock, hang limit, helpers
   always #2 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         num_errors++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   function automatic logic [7:0] outs();
      return {1'b0, power_output_o, overcurrent_high_level_o, overcurrent_low_level_o, overcurrent_low_time_o};
   endfunction
   task automatic state(input logic [1:0] m, input logic wd, input logic pwr);
      chk("mode", mode_o, m);
      chk("watchdog_expired_flag", watchdog_expired_flag_o, wd);
      chk("power", power_output_o, pwr);
   endtask
   task automatic frame(input logic [7:0] tx, input int nbits, input logic [7:0] exp_rx);
      logic [7:0] rx;
      logic oe_ok;
      i_swmw_host.xfer(tx, nbits, rx, oe_ok);
      @(posedge clk_sys_i);
      chk("so_enable", oe_ok, 8'h01);
      chk("so_idle", so_oe_o, 8'h00);
      if (nbits == 8) chk("answer", rx, exp_rx);
   endtask
   // ==========================================================
   // sequence
   initial begin
      tick(4);
      chk("reset_mode", mode_o, 8'h00);
      rst_n_i <= 1'b1;
      tick(10);
      state(M_SLEEP, 1'b0, 1'b0);
      chk("regulator", regulator_en_o, 8'h00);
      battery_supply_ok_i <= 1'b1;
      logic_supply_ok_i <= 1'b1;
      failsafe_select_resistor_i <= FSR_30K;
      wake_i <= 1'b1;
      reset_pin_n_i <= 1'b1;
      tick(10);
      chk("regulator", regulator_en_o, 8'h01);
      foreach (ROWS[r]) begin
         direct_in_i <= ROWS[r].din;
         tg = ~tg;
         frame({tg, ROWS[r].cmd}, 8, ROWS[r].rx);
         tick(10);
         chk("settings", outs(), ROWS[r].outs);
         state(M_NORMAL, 1'b0, ROWS[r].outs[6]);
      end
      frame({~tg, 7'h10}, 7, 8'h00);
      tick(10);
      chk("short_frame", outs(), 8'h76);
      for (int k = 0; k < 6; k++) begin
         fault_det_i <= 6'h01 << k;
         tick(10);
         state(M_FAULT, 1'b0, 1'b0);
         chk("fault_pin", fault_pin, 8'h00);
         fault_det_i <= 6'h00;
         tick(10);
         chk("fault_pin", fault_pin, 8'h01);
         tg = ~tg;
         frame({tg, 7'h01}, 8, 8'h01 << k);
      end
      // same toggle bit: no restart, so the count runs out
      repeat (4) frame({tg, 7'h40}, 8, 8'h00);
      state(M_FAILSAFE, 1'b1, 1'b1);
      chk("oc_default", outs(), 8'h40);
      frame({tg, 7'h40}, 8, 8'h04);
      failsafe_select_resistor_i <= FSR_GND;
      tick(10);
      state(M_NORMAL, 1'b0, 1'b1);
      tick(1500);
      state(M_NORMAL, 1'b0, 1'b1);
      failsafe_select_resistor_i <= FSR_10K;
      reset_pin_n_i <= 1'b0;
      tick(10);
      chk("cleared", outs(), 8'h00);
      reset_pin_n_i <= 1'b1;
      tg = ~tg;
      frame({tg, 7'h41}, 8, 8'h00);
      tg = ~tg;
      frame({tg, 7'h41}, 8, 8'h01);
      tick(1100);
      state(M_NORMAL, 1'b0, 1'b0);
      tick(250);
      state(M_FAILSAFE, 1'b1, 1'b0);
      wake_i <= 1'b0;
      reset_pin_n_i <= 1'b0;
      tick(10);
      state(M_SLEEP, 1'b0, 1'b0);
      chk("regulator", regulator_en_o, 8'h00);
      reset_pin_n_i <= 1'b1;
      failsafe_select_resistor_i <= FSR_GND;
      tick(10);
      state(M_NORMAL, 1'b0, 1'b0);
      tg = ~tg;
      frame({tg, 7'h27}, 8, 8'h00);
      tick(10);
      chk("oc_low", outs(), 8'h1C);
      logic_supply_ok_i <= 1'b0;
      direct_in_i <= 1'b1;
      tick(10);
      chk("no_logic", outs(), 8'h40);
      direct_in_i <= 1'b0;
      tick(10);
      chk("no_logic", outs(), 8'h00);
      battery_supply_ok_i <= 1'b0;
      tick(10);
      state(M_SLEEP, 1'b0, 1'b0);
      test_done();
   end
endmodule // swmw_ctrl_bench
`default_nettype wire
